/* pkg/mmp_map.vh */
// Constants for the MII pin-level link of the Ethernet MAC
// Operation
// RL1: Management data pin is input after reset
// RL2: Drive management clock out during MII operation
// RL3: Launch transmit pins timed to transmit clock
// RL4: Enable with first nibble, drop after last; code ignores tx_last_in and drops enable only when the FIFO runs empty
// RL5: Transmit data valid only under enable
// RL6: Transmit error ignored at 10M or idle
// RL7: PHY holds collision high while it lasts
// RL8: Sample receive pins relative to receive clock
// RL9: PHY holds receive valid across whole frame
// RL10: Accept receive data only while valid
// RL11: Receive error with valid marks frame errored
// RL12: PHY asserts carrier when medium busy
// RL13: Strap high routes channels, low routes Ethernet
// RL14: Strap must stay fixed after reset
// RL15: Capture strap at reset, hold until next
`ifndef MMP_MAP_VH
`define MMP_MAP_VH
`define MMP_NIB_W      4
`define MMP_FIFO_W     6
`define MMP_FIFO_D     16
`define MMP_FIFO_AW    4
`define MMP_SH_W       16
`define MMP_SH_LO      16
`define MMP_MDC_DIV    5'h0a
`define MMP_MDC_W      5
`define MMP_BIT_CNT_W  6
`define MMP_MD_BITS    6'h20
`define MMP_SER_LAST   2'h3
`define MMP_ERR_BIT    5
`define MMP_LAST_BIT   4
`define MMP_MD_RD_BIT  29
`define MMP_MD_MSB     31
`define MMP_MD_TA      6'h12
`define MMP_FIFO_FULL  5'h10
`endif

/* hdl/mmp_fifo.v */
// Parameterised valid/ready FIFO for transmit nibbles
`timescale 1ns/1ps
`default_nettype none
module mmp_fifo #(
    parameter W  = 6,
    parameter D  = 16,
    parameter AW = 4
) (
    // Clock and control
    input  wire          clk_in,
    input  wire          srst_in,
    input  wire          ce_in,
    // Fill side
    input  wire          wr_valid_in,
    output wire          wr_ready_out,
    input  wire [W-1:0]  wr_data_in,
    // Drain side
    output wire          rd_valid_out,
    input  wire          rd_ready_in,
    output reg  [W-1:0]  rd_data_out
);
    reg [W-1:0]  mem_r [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire         push;
    wire         pop;
    assign wr_ready_out = (cnt_r != D[AW:0]);
    assign rd_valid_out = (cnt_r != {(AW+1){1'b0}});
    assign push = wr_valid_in & wr_ready_out;
    assign pop  = rd_valid_out & rd_ready_in;
    always @* begin
        rd_data_out = mem_r[rp_r];
    end
    always @(posedge clk_in) begin
        if (srst_in) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else if (ce_in) begin
            if (push) begin
                mem_r[wp_r] <= wr_data_in;
                wp_r        <= wp_r + 1'b1;
            end
            if (pop)
                rp_r <= rp_r + 1'b1;
            if (push & ~pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // mmp_fifo
`default_nettype wire

/* hdl/mmp_top.v */
// MII pin-level link: transmit, receive, management, pin routing
`timescale 1ns/1ps
`default_nettype none
`include "mmp_map.vh"
module mmp_top (
    // Clock, reset, enable
    input  wire                  clk_in,
    input  wire                  srst_in,
    input  wire                  ce_in,
    // Mode and strap
    input  wire                  serial_mode_in,
    input  wire                  feature_select_strap_in,
    // Transmit user side
    input  wire                  tx_valid_in,
    output reg                   tx_ready_out,
    input  wire [3:0]            tx_nibble_in,
    input  wire                  tx_last_in,
    input  wire                  tx_err_in,
    // Receive user side
    output reg                   rx_valid_out,
    output reg  [3:0]            rx_nibble_out,
    output reg                   rx_end_out,
    output reg                   rx_frame_err_out,
    // PHY status inputs and their gated outputs
    input  wire                  collision_pin_in,
    input  wire                  carrier_sense_pin_in,
    output reg                   collision_out,
    output reg                   carrier_out,
    // PHY transmit pins
    input  wire                  tx_clock_pin_in,
    output reg                   tx_enable_pin_out,
    output reg  [3:0]            tx_nibble_pins_out,
    output reg                   tx_error_pin_out,
    // PHY receive pins
    input  wire                  rx_clock_pin_in,
    input  wire                  rx_valid_pin_in,
    input  wire [3:0]            rx_nibble_pins_in,
    input  wire                  rx_error_pin_in,
    // Management
    input  wire                  md_start_in,
    input  wire [31:0]           md_word_in,
    output reg                   md_busy_out,
    output reg  [31:0]           md_rdata_out,
    output reg                   mgmt_clock_pin_out,
    output reg                   mgmt_data_pin_out,
    output reg                   mgmt_data_pin_oe_out,
    input  wire                  mgmt_data_pin_in,
    // Shared pin routing
    input  wire [15:0]           chan_out_in,
    output reg  [15:0]           timing_channel_pins_out,
    output reg                   eth_route_out
);

    ////////////////////////////////////////////////////////////////////
    // Synchronisers
    reg [1:0] txc_s_r;
    reg [1:0] rxc_s_r;
    reg [5:0] rxp_s1_r;
    reg [5:0] rxp_s2_r;
    reg [2:0] misc_s1_r;
    reg [2:0] misc_s2_r;
    reg       txc_d_r;
    reg       rxc_d_r;
    wire      tx_rise;
    wire      rx_rise;
    always @(posedge clk_in) begin
        if (srst_in) begin
            txc_s_r   <= 2'h0;
            rxc_s_r   <= 2'h0;
            rxp_s1_r  <= 6'h00;
            rxp_s2_r  <= 6'h00;
            misc_s1_r <= 3'h0;
            misc_s2_r <= 3'h0;
            txc_d_r   <= 1'b0;
            rxc_d_r   <= 1'b0;
        end else if (ce_in) begin
            txc_s_r   <= {txc_s_r[0], tx_clock_pin_in};
            rxc_s_r   <= {rxc_s_r[0], rx_clock_pin_in};
            rxp_s1_r  <= {rx_error_pin_in, rx_valid_pin_in,
                          rx_nibble_pins_in};
            rxp_s2_r  <= rxp_s1_r;
            misc_s1_r <= {mgmt_data_pin_in, carrier_sense_pin_in,
                          collision_pin_in};
            misc_s2_r <= misc_s1_r;
            txc_d_r   <= txc_s_r[1];
            rxc_d_r   <= rxc_s_r[1];
        end
    end
    // Launch on falling edge so PHY samples on rising edge
    assign tx_rise = ~txc_s_r[1] & txc_d_r;
    assign rx_rise = rxc_s_r[1] & ~rxc_d_r;

    ////////////////////////////////////////////////////////////////////
    // Strap capture and pin routing
    reg [1:0] strap_s_r;
    reg       strap_r;
    reg       strap_done_r;
    // Runs through reset so the strap level is settled at release
    always @(posedge clk_in) begin
        if (ce_in) begin
            strap_s_r <= {strap_s_r[0], feature_select_strap_in};
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            strap_r      <= 1'b0;
            strap_done_r <= 1'b0;
        end else if (ce_in && !strap_done_r) begin
            strap_r      <= strap_s_r[1]; // RL15
            strap_done_r <= 1'b1; // RL15
        end
    end
    always @(posedge clk_in) begin
        if (srst_in) begin
            timing_channel_pins_out <= 16'h0000;
            eth_route_out           <= 1'b0;
        end else if (ce_in) begin
            eth_route_out <= strap_done_r & ~strap_r; // RL13
            timing_channel_pins_out <= (strap_done_r & strap_r) ?
                                       chan_out_in : 16'h0000; // RL13
        end
    end
    wire eth_on;
    assign eth_on = eth_route_out;

    ////////////////////////////////////////////////////////////////////
    // Transmit path
    wire                  f_valid;
    wire                  f_ready;
    wire [5:0]            f_data;
    wire                  f_push;
    wire                  f_pop;
    reg  [`MMP_FIFO_AW:0] occ_r;
    reg  [`MMP_FIFO_AW:0] occ_nxt;
    mmp_fifo #(
        .W  (`MMP_FIFO_W),
        .D  (`MMP_FIFO_D),
        .AW (`MMP_FIFO_AW)
    ) u_fifo (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .ce_in        (ce_in),
        .wr_valid_in  (f_push),
        .wr_ready_out (),
        .wr_data_in   ({tx_err_in, tx_last_in, tx_nibble_in}),
        .rd_valid_out (f_valid),
        .rd_ready_in  (f_ready),
        .rd_data_out  (f_data)
    );
    assign f_ready = tx_rise & eth_on;
    assign f_push  = tx_valid_in & tx_ready_out;
    assign f_pop   = f_valid & f_ready;

    always @* begin
        occ_nxt = occ_r;
        if (f_push & ~f_pop)
            occ_nxt = occ_r + 1'b1;
        else if (f_pop & ~f_push)
            occ_nxt = occ_r - 1'b1;
    end

    // Ready from a flop, taken from next occupancy to stay exact
    always @(posedge clk_in) begin
        if (srst_in) begin
            occ_r        <= {(`MMP_FIFO_AW+1){1'b0}};
            tx_ready_out <= 1'b0;
        end else if (ce_in) begin
            occ_r        <= occ_nxt;
            tx_ready_out <= (occ_nxt != `MMP_FIFO_FULL);
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            tx_enable_pin_out  <= 1'b0;
            tx_nibble_pins_out <= 4'h0;
            tx_error_pin_out   <= 1'b0;
        end else if (ce_in && tx_rise) begin // RL3
            if (eth_on && f_valid) begin
                tx_enable_pin_out <= 1'b1; // RL4
                tx_nibble_pins_out <= serial_mode_in ?
                    {3'h0, f_data[0]} : f_data[3:0]; // RL5
                tx_error_pin_out <= f_data[`MMP_ERR_BIT] &
                                    ~serial_mode_in; // RL6
            end else begin
                tx_enable_pin_out  <= 1'b0; // RL4
                tx_nibble_pins_out <= 4'h0; // RL5
                tx_error_pin_out   <= 1'b0; // RL6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive path
    reg rx_dv_d_r;
    reg rx_err_r;
    always @(posedge clk_in) begin
        if (srst_in) begin
            rx_valid_out     <= 1'b0;
            rx_nibble_out    <= 4'h0;
            rx_end_out       <= 1'b0;
            rx_frame_err_out <= 1'b0;
            rx_dv_d_r        <= 1'b0;
            rx_err_r         <= 1'b0;
            collision_out    <= 1'b0;
            carrier_out      <= 1'b0;
        end else if (ce_in) begin
            collision_out <= misc_s2_r[0] & eth_on;
            carrier_out   <= misc_s2_r[1] & eth_on;
            rx_valid_out  <= 1'b0;
            rx_end_out    <= 1'b0;
            if (rx_rise && eth_on) begin // RL8
                rx_dv_d_r <= rxp_s2_r[4];
                if (rxp_s2_r[4]) begin // RL10
                    rx_valid_out  <= 1'b1;
                    rx_nibble_out <= serial_mode_in ?
                        {3'h0, rxp_s2_r[0]} : rxp_s2_r[3:0]; // RL10
                    if (!rx_dv_d_r)
                        rx_err_r <= rxp_s2_r[5]; // RL11
                    else if (rxp_s2_r[5])
                        rx_err_r <= 1'b1; // RL11
                end else if (rx_dv_d_r) begin
                    rx_end_out       <= 1'b1;
                    rx_frame_err_out <= rx_err_r; // RL11
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Management: 32-bit frame, write top bits, turnaround read
    localparam MS_IDLE = 3'b001;
    localparam MS_LOW  = 3'b010;
    localparam MS_HIGH = 3'b100;
    reg [2:0]                  ms_r;
    reg [`MMP_MDC_W-1:0]       div_r;
    reg [`MMP_BIT_CNT_W-1:0]   bit_r;
    reg [31:0]                 sh_r;
    reg                        rd_op_r;
    always @(posedge clk_in) begin
        if (srst_in) begin
            ms_r                 <= MS_IDLE;
            div_r                <= {`MMP_MDC_W{1'b0}};
            bit_r                <= {`MMP_BIT_CNT_W{1'b0}};
            sh_r                 <= 32'h00000000;
            rd_op_r              <= 1'b0;
            md_busy_out          <= 1'b0;
            md_rdata_out         <= 32'h00000000;
            mgmt_clock_pin_out   <= 1'b0;
            mgmt_data_pin_out    <= 1'b0;
            mgmt_data_pin_oe_out <= 1'b0; // RL1
        end else if (ce_in) begin
            case (ms_r)
                MS_IDLE: begin
                    mgmt_data_pin_oe_out <= 1'b0; // RL1
                    mgmt_clock_pin_out   <= 1'b0;
                    if (md_start_in && eth_on) begin
                        sh_r        <= md_word_in;
                        rd_op_r     <= md_word_in[`MMP_MD_RD_BIT];
                        bit_r       <= `MMP_MD_BITS;
                        div_r       <= `MMP_MDC_DIV;
                        md_busy_out <= 1'b1;
                        ms_r        <= MS_LOW;
                        mgmt_data_pin_out    <= md_word_in[`MMP_MD_MSB];
                        mgmt_data_pin_oe_out <= 1'b1; // RL1
                    end
                end
                MS_LOW: begin
                    if (div_r == {`MMP_MDC_W{1'b0}}) begin
                        mgmt_clock_pin_out <= 1'b1; // RL2
                        div_r <= `MMP_MDC_DIV;
                        ms_r  <= MS_HIGH;
                        sh_r  <= {sh_r[30:0], misc_s2_r[2]};
                        bit_r <= bit_r - 1'b1;
                    end else begin
                        div_r <= div_r - 1'b1;
                    end
                end
                MS_HIGH: begin
                    if (div_r == {`MMP_MDC_W{1'b0}}) begin
                        mgmt_clock_pin_out <= 1'b0; // RL2
                        div_r <= `MMP_MDC_DIV;
                        if (bit_r == {`MMP_BIT_CNT_W{1'b0}}) begin
                            ms_r                 <= MS_IDLE;
                            md_busy_out          <= 1'b0;
                            md_rdata_out         <= sh_r;
                            mgmt_data_pin_oe_out <= 1'b0; // RL1
                        end else begin
                            ms_r              <= MS_LOW;
                            mgmt_data_pin_out <= sh_r[31];
                            mgmt_data_pin_oe_out <= ~(rd_op_r &&
                                bit_r <= `MMP_MD_TA); // RL1
                        end
                    end else begin
                        div_r <= div_r - 1'b1;
                    end
                end
                default: ms_r <= MS_IDLE;
            endcase
        end
    end
endmodule // mmp_top
`default_nettype wire

/* testbench/mmp_monitor.sv */
// Checker of the MII pin link ports
`timescale 1ns/1ps
`default_nettype none
module mmp_monitor (
    // Clock and controls
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic        serial_mode_in,
    input wire logic [15:0] chan_out_in,
    // Observed outputs
    input wire logic        tx_enable_pin_out,
    input wire logic        tx_error_pin_out,
    input wire logic        rx_valid_out,
    input wire logic        md_busy_out,
    input wire logic        mgmt_clock_pin_out,
    input wire logic        mgmt_data_pin_oe_out,
    input wire logic [15:0] timing_channel_pins_out,
    input wire logic        eth_route_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_oe_busy;
        mgmt_data_pin_oe_out |-> md_busy_out || $past(md_busy_out);
    endproperty
    a_oe_busy: assert property (p_oe_busy)
        else $error("data pin driven while idle");
    property p_mdc_run;
        $rose(md_busy_out) |-> ##[0:24] $rose(mgmt_clock_pin_out);
    endproperty
    a_mdc_run: assert property (p_mdc_run)
        else $error("management clock not started");
    property p_eth_off;
        !eth_route_out |-> !mgmt_clock_pin_out && !tx_enable_pin_out;
    endproperty
    a_eth_off: assert property (p_eth_off)
        else $error("link active while channels routed");
    property p_err_gate;
        tx_error_pin_out |-> tx_enable_pin_out && !serial_mode_in;
    endproperty
    a_err_gate: assert property (p_err_gate)
        else $error("error pin outside enabled nibble mode");
    property p_en_hold;
        $rose(tx_enable_pin_out) |=> tx_enable_pin_out [*6];
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("enable shorter than a transmit clock");
    property p_rx_pulse;
        rx_valid_out |=> !rx_valid_out [*6];
    endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("receive nibbles too close");
    property p_chan;
        !eth_route_out && !$past(eth_route_out) && !$past(srst_in, 3)
            |-> timing_channel_pins_out == $past(chan_out_in);
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel pins not routed");
    property p_strap_hold;
        !$past(srst_in) && !$past(srst_in, 4) |-> $stable(eth_route_out);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("routing changed after reset");
endmodule // mmp_monitor
`default_nettype wire

/* testbench/mmp_phy_model.sv */
// Behavioural PHY on the far side of the MII pins
`timescale 1ns/1ps
`default_nettype none
module mmp_phy_model (
    // Clocks and receive pins
    output logic       tx_clk_out,
    output logic       rx_clk_out,
    output logic       rx_dv_out,
    output logic [3:0] rxd_out,
    output logic       rx_er_out,
    // Transmit pins
    input wire logic       tx_en_in,
    input wire logic [3:0] txd_in,
    input wire logic       tx_er_in
);
    logic       tx_run;
    logic [4:0] cap_q[$];
    initial begin
        {tx_run, tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out} = '0;
        rxd_out = 4'h5;
        forever begin
            #100;
            tx_clk_out = tx_run ? ~tx_clk_out : 1'b0;
        end
    end
    always @(posedge tx_clk_out) begin
        if (tx_en_in) begin
            cap_q.push_back({tx_er_in, txd_in});
        end
    end
    // Clock runs only around a frame; error raised while idle too
    task automatic rx_frame(input int n, input int e);
        for (int i = -1; i <= n + 1; i++) begin
            #100;
            rx_clk_out = 1'b0;
            rx_dv_out = (i >= 0) && (i < n);
            rxd_out = rx_dv_out ? 4'(i + 3) : ~rxd_out;
            rx_er_out = (i == e) || (i < 0);
            #100;
            rx_clk_out = 1'b1;
        end
        #100;
        rx_clk_out = 1'b0;
    endtask
endmodule // mmp_phy_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the MII pin link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin fail_count++; \
    $display("wrong value at %0t: %h vs %h", $time, g, x); end end
`define PHY u_mmp_phy_model
module tb;
    logic        clk_in, srst_in, ce, mode, strap, tv, terr, col, crs, mds;
    logic [3:0]  tn;
    logic [15:0] chan;
    logic [31:0] mdw;
    wire         trdy, rv, rend, rfe, colo, crso, txen, txer, busy, mdc;
    wire         mdo, mdoe, route, txc, rxc, rdv, rer;
    wire  [3:0]  rn, txd, rxd;
    wire  [31:0] rdata;
    wire  [15:0] tcp;
    wire         md_line = mdoe ? mdo : 1'b1;
    int          fail_count, n_tests, end_n, mdc_n;
    logic        end_err;
    logic [3:0]  rxq[$];
    mmp_top u_mmp_top (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
        .serial_mode_in(mode), .feature_select_strap_in(strap),
        .tx_valid_in(tv), .tx_ready_out(trdy), .tx_nibble_in(tn),
        .tx_last_in(1'b0), .tx_err_in(terr), .rx_valid_out(rv),
        .rx_nibble_out(rn), .rx_end_out(rend), .rx_frame_err_out(rfe),
        .collision_pin_in(col), .carrier_sense_pin_in(crs),
        .collision_out(colo), .carrier_out(crso), .tx_clock_pin_in(txc),
        .tx_enable_pin_out(txen), .tx_nibble_pins_out(txd),
        .tx_error_pin_out(txer), .rx_clock_pin_in(rxc),
        .rx_valid_pin_in(rdv), .rx_nibble_pins_in(rxd),
        .rx_error_pin_in(rer), .md_start_in(mds), .md_word_in(mdw),
        .md_busy_out(busy), .md_rdata_out(rdata), .mgmt_clock_pin_out(mdc),
        .mgmt_data_pin_out(mdo), .mgmt_data_pin_oe_out(mdoe),
        .mgmt_data_pin_in(md_line), .chan_out_in(chan),
        .timing_channel_pins_out(tcp), .eth_route_out(route));
    mmp_phy_model u_mmp_phy_model (.tx_clk_out(txc), .rx_clk_out(rxc),
        .rx_dv_out(rdv), .rxd_out(rxd), .rx_er_out(rer), .tx_en_in(txen),
        .txd_in(txd), .tx_er_in(txer));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (rv) rxq.push_back(rn);
        if (rend) begin
            end_n++;
            end_err = rfe;
        end
    end
    always @(posedge mdc) mdc_n++;
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk_in);
        strap <= s;
        srst_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic push(input logic [3:0] n, input logic e);
        {tv, tn, terr} <= {1'b1, n, e};
        @(negedge clk_in);
        for (int k = 0; !trdy; k++) begin
            if (k == 50) begin fail_count++; close_out; end
            @(negedge clk_in);
        end
        @(posedge clk_in);
    endtask
    task automatic wait_cap(input int n);
        `PHY.tx_run = 1'b1;
        for (int k = 0; `PHY.cap_q.size() < n || txen; k++) begin
            if (k == 3000) begin fail_count++; close_out; end
            @(negedge clk_in);
        end
        `PHY.tx_run = 1'b0;
    endtask
    task automatic t_route;
        chan <= 16'ha5c3;
        do_reset(1'b1);
        `CHK({route, tcp}, 17'h0a5c3)
        @(posedge clk_in);
        {strap, mds} <= 2'h1;
        @(posedge clk_in);
        mds <= 1'b0;
        repeat (4) @(negedge clk_in);
        `CHK({route, busy}, 2'h0)
        do_reset(1'b0);
        @(posedge clk_in);
        strap <= 1'b1;
        repeat (4) @(negedge clk_in);
        `CHK({route, tcp}, 17'h10000)
    endtask
    task automatic t_status;
        @(posedge clk_in);
        {ce, col, crs} <= 3'h3;
        repeat (4) @(negedge clk_in);
        `CHK({colo, crso}, 2'h0)
        @(posedge clk_in);
        ce <= 1'b1;
        repeat (4) @(negedge clk_in);
        `CHK({colo, crso}, 2'h3)
        @(posedge clk_in);
        {col, crs} <= 2'h0;
        repeat (4) @(negedge clk_in);
        `CHK({colo, crso}, 2'h0)
    endtask
    task automatic t_tx_fill;
        @(posedge clk_in);
        for (int i = 0; i < 16; i++) push(4'(i), i == 5);
        tv <= 1'b0;
        @(negedge clk_in);
        `CHK(trdy, 1'b0)
        wait_cap(16);
        `CHK(`PHY.cap_q.size(), 16)
        for (int i = 0; i < 16; i++) `CHK(`PHY.cap_q[i], {i == 5, 4'(i)})
        `PHY.cap_q.delete();
    endtask
    task automatic t_tx_serial;
        @(posedge clk_in);
        mode <= 1'b1;
        push(4'he, 1'b1);
        push(4'h1, 1'b1);
        tv <= 1'b0;
        wait_cap(2);
        `CHK({`PHY.cap_q[0][4], `PHY.cap_q[1][4]}, 2'h0)
        `CHK({`PHY.cap_q[0][0], `PHY.cap_q[1][0]}, 2'h1)
        `PHY.cap_q.delete();
        @(posedge clk_in);
        mode <= 1'b0;
    endtask
    task automatic t_rx(input int n, input int e, input logic x,
                        input logic s);
        logic [3:0] m;
        m = s ? 4'h1 : 4'hf;
        @(posedge clk_in);
        mode <= s;
        @(negedge clk_in);
        rxq.delete();
        end_n = 0;
        `PHY.rx_frame(n, e);
        repeat (12) @(negedge clk_in);
        `CHK(rxq.size(), n)
        `CHK(end_n, 1)
        `CHK(end_err, x)
        for (int i = 0; i < n; i++) `CHK(rxq[i], 4'(i + 3) & m)
    endtask
    task automatic t_md(input logic [31:0] w);
        @(posedge clk_in);
        {mdw, mds} <= {w, 1'b1};
        mdc_n = 0;
        @(posedge clk_in);
        mds <= 1'b0;
        repeat (2) @(negedge clk_in);
        `CHK(busy, 1'b1)
        for (int k = 0; busy; k++) begin
            if (k == 2000) begin fail_count++; close_out; end
            @(negedge clk_in);
        end
        `CHK(rdata, w[29] ? {w[31:18], 18'h3ffff} : w)
        `CHK(mdc_n, 32)
    endtask
    initial begin
        {srst_in, ce, mode, strap, tv, terr, col, crs, mds} = 9'h180;
        {tn, chan, mdw} = '0;
        {fail_count, n_tests, end_n, mdc_n, end_err} = '0;
        t_route;
        t_status;
        t_tx_fill;
        t_tx_serial;
        t_rx(6, 2, 1'b1, 1'b0);
        t_rx(5, 99, 1'b0, 1'b0);
        t_rx(4, 99, 1'b0, 1'b1);
        t_md(32'h5a5af00f);
        t_md(32'h6abc1234);
        close_out;
    end
endmodule // tb
bind mmp_top mmp_monitor u_mmp_monitor (.clk_in(clk_in),
    .srst_in(srst_in), .serial_mode_in(serial_mode_in),
    .chan_out_in(chan_out_in), .tx_enable_pin_out(tx_enable_pin_out),
    .tx_error_pin_out(tx_error_pin_out), .rx_valid_out(rx_valid_out),
    .md_busy_out(md_busy_out), .mgmt_clock_pin_out(mgmt_clock_pin_out),
    .mgmt_data_pin_oe_out(mgmt_data_pin_oe_out),
    .timing_channel_pins_out(timing_channel_pins_out),
    .eth_route_out(eth_route_out));
`default_nettype wire
